// *** inc/tcm_pkg.sv ***
// shared constants and types for the thermistor/control pin monitor
package tcm_pkg;
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned BIAS_TIME_MS     = 24;
    localparam int unsigned PRIO_MON_MS      = 35;
    localparam int unsigned STD_MON_MS       = 235;
    localparam int unsigned BIAS_CYCLES      = BIAS_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned PRIO_MON_CYCLES  = PRIO_MON_MS * (CLK_HZ / 1000);
    localparam int unsigned STD_MON_CYCLES   = STD_MON_MS * (CLK_HZ / 1000);
    localparam int unsigned DEGLITCH_CYCLES  = 8;
    localparam int unsigned POWER_MARGIN_MW  = 375;
    localparam int unsigned PWR_W            = 16;
    localparam logic [7:0]  EPT_CODE_INT_FAULT = 8'h02;
    localparam logic [7:0]  EPT_CODE_CHG_DONE  = 8'h01;
    localparam logic [7:0]  EPT_CODE_HOST_FLT  = 8'h02;
    // apb register offsets of the host controller
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_STATUS = 8'h04;
    localparam logic [7:0]  OFS_IRQ    = 8'h08;
    localparam logic [7:0]  OFS_MASK   = 8'h0c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam int unsigned CTRL_DONE_BIT  = 0;
    localparam int unsigned CTRL_FAULT_BIT = 1;
    localparam int unsigned IRQ_BITS       = 2;
    typedef enum logic [1:0] {HOST_IDLE, HOST_DONE, HOST_FAULT} tcm_host_cmd_t;
endpackage : tcm_pkg

// *** inc/tcm_link_if.sv ***
// pin-level link between the receiver and the host driver
`timescale 1ns/10ps
interface tcm_link_if;
    // receiver bias drive on the shared pin
    logic bias_out;
    logic bias_oe;
    // host switch drives
    logic charge_done_drive;
    logic fault_drive;
    // comparator results seen by the receiver
    logic above_high_level;
    logic below_low_level;
    logic hot_trip;
    logic cold_trip;
    modport device (
        output bias_out, bias_oe,
        input  above_high_level, below_low_level, hot_trip, cold_trip
    );
    modport host (
        output charge_done_drive, fault_drive
    );
endinterface : tcm_link_if

// *** hw/tcm_receiver.sv ***
// receiver end: pin bias, temperature check, host detect, thermal and power report
// Contract
// - bias pin 24 ms, deglitched temperature check
// - end window: drop bias, float pin
// - float monitoring 35 or 235 ms
// - high floating pin sets host control flag
// - hot and cold ratiometric thresholds unsafe
// - host default: done drive 1, fault 0
// - pin below low level: fault shutdown
// - pin above high level: charge-complete shutdown
// - host drive codes for done and fault
// - host never drives done 0 fault 1
// - alternative single three-state host output (not built: the host drives separate charge_done_drive and fault_drive outputs)
// - die hot disables regulator, hysteresis restart
// - thermal shutdown sends internal-fault end code
// - report received power averaged over window
// - received power is output plus losses
// - report within 375 mW above calibrated
`timescale 1ns/10ps
module tcm_receiver
    import tcm_pkg::*;
#(
    parameter int unsigned BIAS_CYC  = BIAS_CYCLES,
    parameter int unsigned PRIO_CYC  = PRIO_MON_CYCLES,
    parameter int unsigned STD_CYC   = STD_MON_CYCLES,
    parameter int unsigned DGL_CYC   = DEGLITCH_CYCLES,
    parameter int unsigned AVG_LOG2  = 4
)(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // pin link
    tcm_link_if.device             link,
    // cadence and die temperature
    input  wire logic              priority_cadence,
    input  wire logic              die_at_shutdown_temp,
    input  wire logic              die_below_hysteresis,
    // power measurement inputs in mW
    input  wire logic [PWR_W-1:0]  output_power_mw,
    input  wire logic [PWR_W-1:0]  loss_power_mw,
    input  wire logic              power_sample,
    // status outputs
    output logic                   thermistor_bias_window,
    output logic                   host_control_flag,
    output logic                   temp_unsafe,
    output logic                   receiver_shutdown,
    output logic                   output_regulator_en,
    output logic                   ept_valid,
    output logic [7:0]             ept_code,
    output logic [PWR_W-1:0]       received_power_mw,
    output logic                   received_power_valid
);
    typedef enum logic [0:0] {ST_BIAS, ST_FLOAT} tcm_phase_t;

    // two-flop synchronisers for the comparator and die temperature inputs
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end
        else
        begin
            sync1_reg <= {die_at_shutdown_temp, die_below_hysteresis,
                          link.above_high_level, link.below_low_level,
                          link.hot_trip, link.cold_trip};
            sync2_reg <= sync1_reg;
        end
    end
    wire die_at_s   = sync2_reg[5];
    wire die_cool_s = sync2_reg[4];
    wire above_s = sync2_reg[3];
    wire below_s = sync2_reg[2];
    wire unsafe_raw = sync2_reg[1] | sync2_reg[0];

    // bias and monitor phase timer
    tcm_phase_t  phase_reg;
    logic [23:0] tmr_reg;
    wire [23:0] float_len = priority_cadence ? 24'(PRIO_CYC) : 24'(STD_CYC);
    wire bias_done  = (phase_reg == ST_BIAS) && (tmr_reg == 24'(BIAS_CYC - 1));
    wire float_done = (phase_reg == ST_FLOAT) && (tmr_reg >= float_len - 24'h1);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_reg <= ST_BIAS;
            tmr_reg   <= 24'h0;
        end
        else if (bias_done)
        begin
            phase_reg <= ST_FLOAT;
            tmr_reg   <= 24'h0;
        end
        else if (float_done)
        begin
            phase_reg <= ST_BIAS;
            tmr_reg   <= 24'h0;
        end
        else
            tmr_reg <= tmr_reg + 24'h1;
    end
    wire in_bias = (phase_reg == ST_BIAS);

    // deglitch counters for temperature, high and low pin levels
    logic [15:0] dgl_t_reg;
    logic [15:0] dgl_h_reg;
    logic [15:0] dgl_l_reg;
    wire t_hit = in_bias && unsafe_raw;
    wire h_hit = !in_bias && above_s;
    wire l_hit = !in_bias && below_s;
    wire t_ok  = t_hit && (dgl_t_reg == 16'(DGL_CYC - 1));
    wire h_ok  = h_hit && (dgl_h_reg == 16'(DGL_CYC - 1));
    wire l_ok  = l_hit && (dgl_l_reg == 16'(DGL_CYC - 1));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dgl_t_reg <= 16'h0;
            dgl_h_reg <= 16'h0;
            dgl_l_reg <= 16'h0;
        end
        else
        begin
            dgl_t_reg <= (t_hit && !t_ok) ? dgl_t_reg + 16'h1 : (t_ok ? dgl_t_reg : 16'h0);
            dgl_h_reg <= (h_hit && !h_ok) ? dgl_h_reg + 16'h1 : (h_ok ? dgl_h_reg : 16'h0);
            dgl_l_reg <= (l_hit && !l_ok) ? dgl_l_reg + 16'h1 : (l_ok ? dgl_l_reg : 16'h0);
        end
    end

    // thermal shutdown with hysteresis
    logic die_hot_reg;
    wire die_hot_next = die_at_s ? 1'b1
                      : (die_cool_s ? 1'b0 : die_hot_reg);
    wire die_trip = die_at_s && !die_hot_reg;

    // shutdown causes; host shutdown is latched until reset
    wire host_done  = h_ok;
    wire host_fault = l_ok;
    wire any_stop   = host_done || host_fault || t_ok || die_trip;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            die_hot_reg            <= 1'b0;
            thermistor_bias_window <= 1'b1;
            host_control_flag      <= 1'b0;
            temp_unsafe            <= 1'b0;
            receiver_shutdown      <= 1'b0;
            output_regulator_en    <= 1'b0;
            ept_valid              <= 1'b0;
            ept_code               <= 8'h00;
        end
        else
        begin
            die_hot_reg            <= die_hot_next;
            thermistor_bias_window <= in_bias ? !bias_done : float_done;
            host_control_flag      <= host_control_flag | host_done;
            temp_unsafe            <= t_ok ? 1'b1 : (bias_done ? 1'b0 : temp_unsafe);
            receiver_shutdown      <= receiver_shutdown | host_done | host_fault;
            output_regulator_en    <= !die_hot_next && !receiver_shutdown
                                      && !host_done && !host_fault && !temp_unsafe;
            ept_valid              <= any_stop;
            if (die_trip)
                ept_code <= EPT_CODE_INT_FAULT;
            else if (host_done)
                ept_code <= EPT_CODE_CHG_DONE;
            else if (host_fault || t_ok)
                ept_code <= EPT_CODE_HOST_FLT;
        end
    end

    // pin drive: bias only during the window, float otherwise
    always_comb
    begin
        link.bias_out = 1'b1;
        link.bias_oe  = thermistor_bias_window;
    end

    // received power: output plus losses, averaged over 2**AVG_LOG2 samples
    wire [PWR_W:0] inst_pwr = {1'b0, output_power_mw} + {1'b0, loss_power_mw};
    logic [PWR_W+AVG_LOG2:0] acc_reg;
    logic [AVG_LOG2-1:0]     cnt_reg;
    wire [PWR_W+AVG_LOG2:0] acc_sum = acc_reg + (PWR_W+AVG_LOG2+1)'(inst_pwr);
    wire [PWR_W+AVG_LOG2:0] avg_val = acc_sum >> AVG_LOG2;
    wire win_end = power_sample && (cnt_reg == {AVG_LOG2{1'b1}});
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_reg              <= '0;
            cnt_reg              <= '0;
            received_power_mw    <= '0;
            received_power_valid <= 1'b0;
        end
        else
        begin
            received_power_valid <= win_end;
            if (power_sample)
            begin
                cnt_reg <= cnt_reg + 1'b1;
                acc_reg <= win_end ? '0 : acc_sum;
            end
            if (win_end)
                received_power_mw <= (avg_val > (PWR_W+AVG_LOG2+1)'({PWR_W{1'b1}}))
                                     ? {PWR_W{1'b1}} : avg_val[PWR_W-1:0];
        end
    end
endmodule : tcm_receiver

// *** hw/tcm_host.sv ***
// host end: apb-controlled gpio drive of the shared pin
`timescale 1ns/10ps
module tcm_host
    import tcm_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // receiver status to watch
    input  wire logic        rx_shutdown,
    input  wire logic        rx_ept_valid,
    // pin link
    tcm_link_if.host         link,
    // interrupt
    output logic             irq
);
    logic [31:0]         ctrl_reg;
    logic [IRQ_BITS-1:0] stat_reg;
    logic [IRQ_BITS-1:0] mask_reg;
    logic [1:0]          sync1_reg;
    logic [1:0]          sync2_reg;
    logic [1:0]          prev_reg;

    wire acc     = psel && penable;
    wire wr      = acc && pwrite;
    wire hit_ctl = paddr == OFS_CTRL;
    wire hit_sta = paddr == OFS_STATUS;
    wire hit_irq = paddr == OFS_IRQ;
    wire hit_msk = paddr == OFS_MASK;
    wire mapped  = hit_ctl | hit_sta | hit_irq | hit_msk;
    wire req_done  = ctrl_reg[CTRL_DONE_BIT];
    wire req_fault = ctrl_reg[CTRL_FAULT_BIT] && !req_done;
    wire [1:0] ev = {sync2_reg[1] & ~prev_reg[1], sync2_reg[0] & ~prev_reg[0]};
    wire [IRQ_BITS-1:0] clr = (wr && hit_irq) ? pwdata[IRQ_BITS-1:0] : '0;
    wire [31:0] rd_val = hit_ctl ? ctrl_reg
                       : hit_sta ? {30'h0, sync2_reg}
                       : hit_irq ? {30'h0, stat_reg}
                       : hit_msk ? {30'h0, mask_reg} : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg  <= CTRL_RESET;
            mask_reg  <= MASK_RESET[IRQ_BITS-1:0];
            stat_reg  <= '0;
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            prev_reg  <= 2'h0;
            prdata    <= 32'h0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            irq       <= 1'b0;
            link.charge_done_drive <= 1'b1;
            link.fault_drive       <= 1'b0;
        end
        else
        begin
            sync1_reg <= {rx_ept_valid, rx_shutdown};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            pready    <= psel && !penable;
            pslverr   <= psel && !penable && !mapped;
            prdata    <= (psel && !penable && !pwrite) ? rd_val : 32'h0;
            if (wr && hit_ctl)
                ctrl_reg <= {30'h0, pwdata[1:0]};
            if (wr && hit_msk)
                mask_reg <= pwdata[IRQ_BITS-1:0];
            stat_reg <= (stat_reg & ~clr) | ev;
            irq      <= |(((stat_reg & ~clr) | ev) & mask_reg);
            link.charge_done_drive <= !req_done;
            link.fault_drive       <= req_fault;
        end
    end
endmodule : tcm_host

// *** verification/tcm_checker.sv ***
// concurrent checks on the pin link between receiver and host
`timescale 1ns/10ps
module tcm_checker #(
    parameter int unsigned BIAS_CYC = 40,
    parameter int unsigned PRIO_CYC = 60,
    parameter int unsigned STD_CYC  = 100
)(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // receiver side of the pin
    input wire logic bias_out,
    input wire logic bias_oe,
    input wire logic above_high_level,
    input wire logic below_low_level,
    input wire logic hot_trip,
    input wire logic cold_trip,
    // host switch drives
    input wire logic charge_done_drive,
    input wire logic fault_drive
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] on_cnt;
    logic [15:0] off_cnt;
    logic        seen_rise;
    // window lengths, the first window after reset is skipped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            on_cnt    <= 16'h0;
            off_cnt   <= 16'h0;
            seen_rise <= 1'b0;
        end
        else
        begin
            on_cnt    <= bias_oe ? on_cnt + 16'h1 : 16'h0;
            off_cnt   <= bias_oe ? 16'h0 : off_cnt + 16'h1;
            seen_rise <= seen_rise | (bias_oe & (off_cnt != 16'h0));
        end
    end
    no_short_drive_a: assert property (!(!charge_done_drive && fault_drive))
        else $error("host drives both switches on");
    bias_level_a: assert property (bias_oe |-> bias_out)
        else $error("bias drive level wrong");
    bias_len_a: assert property ($fell(bias_oe) && seen_rise |-> on_cnt == BIAS_CYC)
        else $error("bias window length wrong");
    float_len_a: assert property ($rose(bias_oe) |-> off_cnt == PRIO_CYC || off_cnt == STD_CYC)
        else $error("float interval length wrong");
    bias_hold_a: assert property ($rose(bias_oe) |=> bias_oe [*8])
        else $error("bias window cut short");
    float_hold_a: assert property ($fell(bias_oe) |=> !bias_oe [*8])
        else $error("pin left floating too briefly");
    fault_order_a: assert property ($rose(fault_drive) |-> charge_done_drive)
        else $error("fault drive without done switch off");
    done_order_a: assert property ($fell(charge_done_drive) |-> !fault_drive)
        else $error("done drive with fault switch on");
    cover property ($fell(bias_oe));
    cover property ($rose(fault_drive));
    cover property ($fell(charge_done_drive));
endmodule : tcm_checker

// *** verification/thermistor_control_pin_monitor_tb.sv ***
// bench joining receiver and host over the pin link
`timescale 1ns/10ps
module thermistor_control_pin_monitor_tb;
    import tcm_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, err;
    logic        prio = 1'b1, die_hot = 1'b0, die_cool = 1'b1, psamp = 1'b0;
    logic        tbw, hcf, unsafe, shut, reg_en, ept_v, pwr_v;
    logic [1:0]  trip = 2'b00;
    logic [7:0]  ept_c, last_code = 8'h00;
    logic [15:0] pwr, pwr_seen = 16'h0;
    logic [15:0] pout = 16'h03e0, ploss = 16'h00c8;
    int          n_errors = 0, total_checks = 0, cyc = 0, n;
    tcm_link_if tcm_link_if_inst ();
    wire logic done_d = tcm_link_if_inst.charge_done_drive;
    wire logic flt_d  = tcm_link_if_inst.fault_drive;
    wire logic oe     = tcm_link_if_inst.bias_oe;
    // pin model: host switches pull the pin past the comparator levels
    assign tcm_link_if_inst.above_high_level = !done_d;
    assign tcm_link_if_inst.below_low_level  = flt_d;
    assign tcm_link_if_inst.hot_trip         = trip[0];
    assign tcm_link_if_inst.cold_trip        = trip[1];
    always #25 pclk = ~pclk;
    tcm_receiver #(.BIAS_CYC(40), .PRIO_CYC(60), .STD_CYC(100)) tcm_receiver_inst (
        .pclk(pclk), .presetn(presetn), .link(tcm_link_if_inst.device),
        .priority_cadence(prio), .die_at_shutdown_temp(die_hot), .die_below_hysteresis(die_cool),
        .output_power_mw(pout), .loss_power_mw(ploss), .power_sample(psamp),
        .thermistor_bias_window(tbw), .host_control_flag(hcf), .temp_unsafe(unsafe),
        .receiver_shutdown(shut), .output_regulator_en(reg_en), .ept_valid(ept_v),
        .ept_code(ept_c), .received_power_mw(pwr), .received_power_valid(pwr_v));
    tcm_host tcm_host_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_shutdown(shut), .rx_ept_valid(ept_v), .link(tcm_link_if_inst.host), .irq(irq));
    tcm_checker tcm_checker_inst (
        .pclk(pclk), .presetn(presetn), .bias_out(tcm_link_if_inst.bias_out), .bias_oe(oe),
        .above_high_level(tcm_link_if_inst.above_high_level),
        .below_low_level(tcm_link_if_inst.below_low_level), .hot_trip(trip[0]),
        .cold_trip(trip[1]), .charge_done_drive(done_d), .fault_drive(flt_d));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (ept_v)
            last_code <= ept_c;
        if (pwr_v)
            pwr_seen <= pwr;
        if (cyc == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        if (seen !== exp)
            n_errors++;
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready)
            @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wc(input int k);
        repeat (k) @(posedge pclk);
    endtask : wc
    task automatic span(input logic lvl, output int k);
        k = 0;
        while (tbw === lvl)
        begin
            k++;
            @(posedge pclk);
        end
    endtask : span
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        check({tbw, done_d, flt_d, irq}, 4'b1100);
        check({tcm_link_if_inst.above_high_level, tcm_link_if_inst.below_low_level}, 2'b00);
        span(1'b1, n);
        span(1'b0, n);
        span(1'b1, n);
        check(n, 40);
        check(oe, 0);
        span(1'b0, n);
        check(n, 60);
        prio <= 1'b0;
        span(1'b1, n);
        span(1'b0, n);
        check(n, 100);
        $display("end of test windows");
        check(reg_en, 1);
        die_hot  <= 1'b1;
        die_cool <= 1'b0;
        wc(6);
        check({reg_en, last_code}, {1'b0, EPT_CODE_INT_FAULT});
        die_hot  <= 1'b0;
        die_cool <= 1'b1;
        wc(6);
        check(reg_en, 1);
        for (int k = 0; k < 2; k++)
        begin
            span(1'b0, n);
            last_code <= 8'h00;
            trip <= 2'b01 << k;
            wc(14);
            check({unsafe, reg_en, last_code}, {2'b10, EPT_CODE_INT_FAULT});
            trip <= 2'b00;
            span(1'b1, n);
            wc(2);
            check(unsafe, 0);
        end
        $display("end of test temperature");
        for (int k = 0; k < 16; k++)
        begin
            psamp <= 1'b1;
            pout  <= 16'h03e0 + 16'(k);
            @(posedge pclk);
            psamp <= 1'b0;
            @(posedge pclk);
        end
        wc(3);
        check(pwr_seen, 16'h04af);
        check(pwr_seen - 16'h03e8 < 16'h0177, 1);
        $display("end of test power");
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, CTRL_RESET);
        apb(1'b0, OFS_MASK, 32'h0);
        check(rd, MASK_RESET);
        apb(1'b1, OFS_CTRL, 32'h1);
        wc(2);
        check({done_d, flt_d}, 2'b00);
        wc(200);
        check({hcf, shut, last_code}, {2'b11, EPT_CODE_CHG_DONE});
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[0], 1);
        apb(1'b0, OFS_IRQ, 32'h0);
        check({irq, rd}, {1'b0, 32'h3});
        apb(1'b1, OFS_MASK, 32'h1);
        wc(3);
        check(irq, 1);
        apb(1'b1, OFS_IRQ, 32'h3);
        wc(3);
        check(irq, 0);
        apb(1'b0, 8'h10, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        $display("end of test charge done");
        presetn <= 1'b0;
        wc(5);
        presetn <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h2);
        wc(2);
        check({done_d, flt_d}, 2'b11);
        wc(200);
        check({hcf, shut, last_code}, {2'b01, EPT_CODE_HOST_FLT});
        apb(1'b1, OFS_CTRL, 32'h3);
        wc(2);
        check({done_d, flt_d}, 2'b00);
        $display("end of test fault");
        give_verdict();
    end
endmodule : thermistor_control_pin_monitor_tb
